// ===== include/wit_defs.vh
// constants for the watch interval timer
`ifndef WIT_DEFS_VH
`define WIT_DEFS_VH

// register indices; byte address is four times the index
`define WIT_IDX_MODE 8'h9D
`define WIT_IDX_PERIOD 8'h9E
`define WIT_IDX_STATUS 8'hA0
`define WIT_IDX_CLEAR 8'hA1
`define WIT_IDX_ENABLE 8'hA2
`define WIT_ADDR_MODE {2'h0, `WIT_IDX_MODE, 2'h0}
`define WIT_ADDR_PERIOD {2'h0, `WIT_IDX_PERIOD, 2'h0}
`define WIT_ADDR_STATUS {2'h0, `WIT_IDX_STATUS, 2'h0}
`define WIT_ADDR_CLEAR {2'h0, `WIT_IDX_CLEAR, 2'h0}
`define WIT_ADDR_ENABLE {2'h0, `WIT_IDX_ENABLE, 2'h0}
`define WIT_ADDR_W 12

// mode register fields
`define WIT_MODE_RUN 7
`define WIT_MODE_FLAG 4
`define WIT_MODE_IVL_HI 3
`define WIT_MODE_IVL_LO 2
`define WIT_MODE_CK_HI 1
`define WIT_MODE_CK_LO 0
`define WIT_MODE_MASK 8'h9F

// period register fields
`define WIT_PER_CLR 7
`define WIT_PER_HI 6

// reset values
`define WIT_RST_MODE 8'h00
`define WIT_RST_PERIOD 7'h7F

// interval select codes
`define WIT_IVL_2K 2'h0
`define WIT_IVL_8K 2'h1
`define WIT_IVL_16K 2'h2
`define WIT_IVL_PER 2'h3

// source select codes
`define WIT_CK_SUB 2'h0
`define WIT_CK_FX256 2'h1
`define WIT_CK_FX128 2'h2
`define WIT_CK_FX64 2'h3

// prescaler and divider tap positions
`define WIT_PRE_W 14
`define WIT_CNT_W 7
`define WIT_FXDIV_W 8
`define WIT_TAP_2K 10
`define WIT_TAP_8K 12
`define WIT_TAP_16K 13
`define WIT_TAP_FX64 5
`define WIT_TAP_FX128 6
`define WIT_TAP_FX256 7

// nominal sub clock frequency in Hz
`define WIT_SUB_HZ 32768

`endif

// ===== verilog/wit_pow2_div.v
// free binary divider giving one-cycle ticks at every power of two
`timescale 1ns/1ps
module wit_pow2_div #(
  parameter W = 8
) (
  input wire clk,          // core clock
  input wire clr,          // synchronous clear to zero
  input wire en,           // count enable pulse
  output wire [W-1:0] tick // tick[k] pulses every 2^(k+1) enables
);

reg [W-1:0] cnt;

always @(posedge clk) begin
  if (clr) begin
    cnt <= {W{1'b0}};
  end else if (en) begin
    cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
  end
end

////////////////////////////////////////////////////////////////////////////////
genvar k;
generate
  for (k = 0; k < W; k = k + 1) begin : g_tap
    assign tick[k] = en & (&cnt[k:0]) & ~clr;
  end
endgenerate

endmodule

// ===== verilog/wit_watch_timer.v
// watch interval timer with ahb-lite register slave
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "wit_defs.vh"
module wit_watch_timer (
  input wire CORE_CLK,          // core clock, 200 MHz
  input wire SRST,              // synchronous reset, active high
  input wire HSEL,              // ahb slave select
  input wire [31:0] HADDR,      // ahb address
  input wire [1:0] HTRANS,      // ahb transfer type
  input wire HWRITE,            // ahb write
  input wire [2:0] HSIZE,       // ahb size
  input wire HREADY,            // ahb bus ready
  input wire [31:0] HWDATA,     // ahb write data
  output wire [31:0] HRDATA,    // ahb read data
  output wire HREADYOUT,        // ahb slave ready
  output wire HRESP,            // ahb response, always okay
  input wire SUB_CLK,           // sub clock oscillator pin
  input wire STOP_MODE,         // processor stop mode, main clock halted
  input wire INT_ACK,           // acknowledge from interrupt controller
  output wire WATCH_IRQ_REQ,    // request to interrupt controller
  output wire IRQ               // level interrupt, enabled status
);

////////////////////////////////////////////////////////////////////////////////
// bus state

reg wr_pend;
reg [`WIT_ADDR_W-1:0] wr_addr;
reg [31:0] rd_data;
wire addr_phase;
wire [`WIT_ADDR_W-1:0] a_addr;

// control and status
reg watch_run_enable;
reg watch_irq_flag;
reg [1:0] interval_select;
reg [1:0] watch_clk_select;
reg [6:0] period;
reg watch_count_clear;
reg [6:0] upper_cnt;
reg status_evt;
reg enable_evt;
wire [7:0] mode_rst;

// sub clock synchroniser and edge filter
reg sub_s1;
reg sub_s2;
reg sub_s3;
reg sub_lvl;
wire sub_rise;

// clock tick and prescaler
wire [`WIT_FXDIV_W-1:0] fx_tick;
wire [`WIT_PRE_W-1:0] pre_tick;
wire fx_run;
reg wck_tick;
wire cnt_clr;
reg ivl_done;
wire upper_hit;

// register writes decoded in data phase
wire wr_mode;
wire wr_period;
wire wr_clear;
wire wr_enable;

////////////////////////////////////////////////////////////////////////////////
// ahb-lite slave, zero wait states

assign addr_phase = HSEL & HTRANS[1] & HREADY;
assign a_addr = HADDR[`WIT_ADDR_W-1:0];
assign HREADYOUT = 1'b1;
assign HRESP = 1'b0;
assign HRDATA = rd_data;

always @(posedge CORE_CLK) begin
  if (SRST) begin
    wr_pend <= 1'b0;
    wr_addr <= {`WIT_ADDR_W{1'b0}};
  end else begin
    wr_pend <= addr_phase & HWRITE;
    if (addr_phase) begin
      wr_addr <= a_addr;
    end
  end
end

assign wr_mode = wr_pend & (wr_addr == `WIT_ADDR_MODE);
assign wr_period = wr_pend & (wr_addr == `WIT_ADDR_PERIOD);
assign wr_clear = wr_pend & (wr_addr == `WIT_ADDR_CLEAR);
assign wr_enable = wr_pend & (wr_addr == `WIT_ADDR_ENABLE);

// read data captured at the address phase, shown in the data phase
always @(posedge CORE_CLK) begin
  if (SRST) begin
    rd_data <= 32'h00000000;
  end else if (addr_phase & ~HWRITE) begin
    case (a_addr)
      `WIT_ADDR_MODE: begin
        rd_data <= {24'h000000, watch_run_enable, 2'h0, watch_irq_flag,
                    interval_select, watch_clk_select};
      end
      `WIT_ADDR_PERIOD: begin
        rd_data <= {25'h0, upper_cnt};
      end
      `WIT_ADDR_STATUS: begin
        rd_data <= {31'h0, status_evt};
      end
      `WIT_ADDR_ENABLE: begin
        rd_data <= {31'h0, enable_evt};
      end
      default: begin
        rd_data <= 32'h00000000;
      end
    endcase
  end else begin
    rd_data <= 32'h00000000;
  end
end

////////////////////////////////////////////////////////////////////////////////
// mode register

assign mode_rst = `WIT_RST_MODE;

always @(posedge CORE_CLK) begin
  if (SRST) begin
    watch_run_enable <= mode_rst[`WIT_MODE_RUN];
    interval_select <= mode_rst[`WIT_MODE_IVL_HI:`WIT_MODE_IVL_LO];
    watch_clk_select <= mode_rst[`WIT_MODE_CK_HI:`WIT_MODE_CK_LO];
  end else if (wr_mode) begin
    watch_run_enable <= HWDATA[`WIT_MODE_RUN];
    interval_select <= HWDATA[`WIT_MODE_IVL_HI:`WIT_MODE_IVL_LO];
    watch_clk_select <= HWDATA[`WIT_MODE_CK_HI:`WIT_MODE_CK_LO];
  end
end

// flag: interval end sets, zero write or acknowledge clears, set wins
always @(posedge CORE_CLK) begin
  if (SRST) begin
    watch_irq_flag <= 1'b0;
  end else if (ivl_done) begin
    watch_irq_flag <= 1'b1;
  end else if (INT_ACK) begin
    watch_irq_flag <= 1'b0;
  end else if (wr_mode & ~HWDATA[`WIT_MODE_FLAG]) begin
    watch_irq_flag <= 1'b0;
  end
end

assign WATCH_IRQ_REQ = watch_irq_flag;

////////////////////////////////////////////////////////////////////////////////
// period register and self-clearing count clear

always @(posedge CORE_CLK) begin
  if (SRST) begin
    period <= `WIT_RST_PERIOD;
  end else if (wr_period) begin
    period <= HWDATA[`WIT_PER_HI:0];
  end
end

always @(posedge CORE_CLK) begin
  if (SRST) begin
    watch_count_clear <= 1'b0;
  end else if (wr_period & HWDATA[`WIT_PER_CLR]) begin
    watch_count_clear <= 1'b1;
  end else begin
    watch_count_clear <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// sub clock pin: three flops, a change counts when second and third agree

always @(posedge CORE_CLK) begin
  if (SRST) begin
    sub_s1 <= 1'b0;
    sub_s2 <= 1'b0;
    sub_s3 <= 1'b0;
    sub_lvl <= 1'b0;
  end else begin
    sub_s1 <= SUB_CLK;
    sub_s2 <= sub_s1;
    sub_s3 <= sub_s2;
    if (sub_s2 == sub_s3) begin
      sub_lvl <= sub_s3;
    end
  end
end

// one tick per rising edge of the nominal 32.768 kHz crystal
assign sub_rise = sub_s2 & sub_s3 & ~sub_lvl;

////////////////////////////////////////////////////////////////////////////////
// main clock divider, halted in stop mode as the main oscillator is

assign fx_run = ~STOP_MODE;

wit_pow2_div #(
  .W(`WIT_FXDIV_W)
) u_fx_div (
  .clk(CORE_CLK),
  .clr(SRST),
  .en(fx_run),
  .tick(fx_tick)
);

// watch clock select; sub clock path ignores stop mode
always @* begin
  case (watch_clk_select)
    `WIT_CK_SUB: begin
      wck_tick = sub_rise;
    end
    `WIT_CK_FX256: begin
      wck_tick = fx_tick[`WIT_TAP_FX256];
    end
    `WIT_CK_FX128: begin
      wck_tick = fx_tick[`WIT_TAP_FX128];
    end
    `WIT_CK_FX64: begin
      wck_tick = fx_tick[`WIT_TAP_FX64];
    end
    default: begin
      wck_tick = 1'b0;
    end
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// 14-bit prescaler, held at zero while stopped or cleared

assign cnt_clr = SRST | ~watch_run_enable | watch_count_clear;

wit_pow2_div #(
  .W(`WIT_PRE_W)
) u_prescale (
  .clk(CORE_CLK),
  .clr(cnt_clr),
  .en(wck_tick),
  .tick(pre_tick)
);

// 7-bit auto-reload section counts full prescaler wraps up to the period
assign upper_hit = pre_tick[`WIT_TAP_16K] & (upper_cnt == period);

always @(posedge CORE_CLK) begin
  if (cnt_clr) begin
    upper_cnt <= 7'h00;
  end else if (upper_hit) begin
    upper_cnt <= 7'h00;
  end else if (pre_tick[`WIT_TAP_16K]) begin
    upper_cnt <= upper_cnt + 7'h01;
  end
end

// interval end selection
always @* begin
  case (interval_select)
    `WIT_IVL_2K: begin
      ivl_done = pre_tick[`WIT_TAP_2K];
    end
    `WIT_IVL_8K: begin
      ivl_done = pre_tick[`WIT_TAP_8K];
    end
    `WIT_IVL_16K: begin
      ivl_done = pre_tick[`WIT_TAP_16K];
    end
    `WIT_IVL_PER: begin
      ivl_done = upper_hit;
    end
    default: begin
      ivl_done = 1'b0;
    end
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// sticky status, write-one-to-clear, enable gating; set wins over clear

always @(posedge CORE_CLK) begin
  if (SRST) begin
    status_evt <= 1'b0;
  end else if (ivl_done) begin
    status_evt <= 1'b1;
  end else if (wr_clear & HWDATA[0]) begin
    status_evt <= 1'b0;
  end
end

always @(posedge CORE_CLK) begin
  if (SRST) begin
    enable_evt <= 1'b0;
  end else if (wr_enable) begin
    enable_evt <= HWDATA[0];
  end
end

assign IRQ = status_evt & enable_evt;

endmodule

// ===== verilog/_unused_placeholder_removed.v
// intentionally empty design file note
`timescale 1ns/1ps

// ===== testbench/wit_watch_timer_assertions.sv
// port checker for the watch interval timer
`timescale 1ns/1ps
`include "wit_defs.vh"
module wit_watch_timer_chk (
  input wire CORE_CLK,       // clock
  input wire SRST,           // reset
  input wire HSEL,           // select
  input wire [31:0] HADDR,   // address
  input wire [1:0] HTRANS,   // transfer
  input wire HWRITE,         // write
  input wire HREADY,         // ready in
  input wire [31:0] HWDATA,  // write data
  input wire [31:0] HRDATA,  // read data
  input wire HREADYOUT,      // ready out
  input wire HRESP,          // response
  input wire INT_ACK,        // acknowledge
  input wire WATCH_IRQ_REQ,  // request
  input wire IRQ             // interrupt
);
  reg wr_mode;
  reg rd_ph;
  wire take = HSEL && HTRANS[1] && HREADY;
  always @(posedge CORE_CLK) begin
    wr_mode <= !SRST && take && HWRITE && HADDR[11:0] == `WIT_ADDR_MODE;
    rd_ph <= !SRST && take && !HWRITE;
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  a_ready_always: assert property (HREADYOUT == 1'b1) else $error("ready dropped");
  a_resp_okay: assert property (HRESP == 1'b0) else $error("response not okay");
  a_reset_quiet: assert property (disable iff (1'b0) SRST |=> HRDATA == 32'h0 && !WATCH_IRQ_REQ && !IRQ)
    else $error("outputs active after reset");
  a_rdata_idle: assert property (!rd_ph |-> HRDATA == 32'h0) else $error("read data outside read");
  a_rdata_width: assert property (HRDATA[31:8] == 24'h0) else $error("upper read bits set");
  a_ack_clears: assert property (INT_ACK && WATCH_IRQ_REQ |=> !WATCH_IRQ_REQ)
    else $error("acknowledge kept flag");
  a_write_zero_clears: assert property (wr_mode && !HWDATA[`WIT_MODE_FLAG] |=> !WATCH_IRQ_REQ)
    else $error("write zero kept flag");
  a_req_holds: assert property (WATCH_IRQ_REQ && !INT_ACK && !wr_mode |=> WATCH_IRQ_REQ)
    else $error("request dropped");
  cover property ($rose(WATCH_IRQ_REQ));
  cover property (IRQ);
  cover property (INT_ACK && WATCH_IRQ_REQ);
endmodule
bind wit_watch_timer wit_watch_timer_chk u_chk (.CORE_CLK, .SRST, .HSEL, .HADDR, .HTRANS,
  .HWRITE, .HREADY, .HWDATA, .HRDATA, .HREADYOUT, .HRESP, .INT_ACK, .WATCH_IRQ_REQ, .IRQ);

// ===== testbench/tb_wit_watch_timer.sv
// self-checking bench for the watch interval timer
`timescale 1ns/1ps
`include "wit_defs.vh"
module tb_wit_watch_timer;
  reg CORE_CLK = 0, SRST = 1, HSEL = 0, HWRITE = 0;
  reg SUB_CLK = 0, STOP_MODE = 0, INT_ACK = 0;
  reg [31:0] HADDR = 0, HWDATA = 0;
  reg [1:0] HTRANS = 0;
  wire [31:0] HRDATA;
  wire HREADYOUT, HRESP, WATCH_IRQ_REQ, IRQ;
  integer errors = 0, check_count = 0, cyc = 0, t1, n;
  reg [31:0] d;
  localparam integer SUB_CYC = 6;
  localparam integer IVL_2K = 2048 * SUB_CYC;
  localparam integer IVL_8K = 8192 * SUB_CYC;
  wit_watch_timer DUT (.CORE_CLK(CORE_CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HREADY(HREADYOUT), .HWDATA(HWDATA),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SUB_CLK(SUB_CLK),
    .STOP_MODE(STOP_MODE), .INT_ACK(INT_ACK), .WATCH_IRQ_REQ(WATCH_IRQ_REQ), .IRQ(IRQ));
  initial forever #2.5 CORE_CLK = ~CORE_CLK;
  // sub clock: 6 core cycles a period, three high and three low, edges away from core edges
  initial begin
    #1;
    forever #15 SUB_CLK = ~SUB_CLK;
  end
  ////////////////////////////////////////////////////////////////////////////
  task test_done;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input [31:0] s, input [31:0] e);
    check_count = check_count + 1;
    if (s !== e) begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task bus(input w, input [11:0] a, input [31:0] wd, output [31:0] rd);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {20'h0, a};
    HWRITE <= w;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask
  task wait_req;
    n = 0;
    while (WATCH_IRQ_REQ !== 1'b1 && n < 60000) begin
      @(posedge CORE_CLK);
      n = n + 1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      errors = errors + 1;
      test_done;
    end
  end
  initial begin
    repeat (6) @(posedge CORE_CLK);
    SRST <= 1'b0;
    @(posedge CORE_CLK);
    bus(0, `WIT_ADDR_MODE, 0, d); chk("mode", d, 32'h0);
    bus(0, `WIT_ADDR_PERIOD, 0, d); chk("count", d, 32'h0);
    bus(0, `WIT_ADDR_STATUS, 0, d); chk("status", d, 32'h0);
    bus(0, 12'h000, 0, d); chk("unmapped", d, 32'h0);
    $display("test reset values done");
    // sub clock source keeps counting with the main clock halted
    STOP_MODE <= 1'b1;
    bus(1, `WIT_ADDR_MODE, 32'h80, d);
    wait_req;
    t1 = cyc;
    chk("first interval", n >= IVL_2K - 16 && n <= IVL_2K + 16, 1);
    bus(0, `WIT_ADDR_MODE, 0, d); chk("flag set", d, 32'h90);
    bus(0, `WIT_ADDR_STATUS, 0, d); chk("status set", d, 32'h1);
    chk("masked", IRQ, 1'b0);
    bus(1, `WIT_ADDR_ENABLE, 32'h1, d);
    @(posedge CORE_CLK);
    chk("irq on", IRQ, 1'b1);
    INT_ACK <= 1'b1;
    @(posedge CORE_CLK);
    INT_ACK <= 1'b0;
    @(posedge CORE_CLK);
    chk("ack clear", WATCH_IRQ_REQ, 1'b0);
    chk("sticky", IRQ, 1'b1);
    bus(1, `WIT_ADDR_CLEAR, 32'h1, d);
    @(posedge CORE_CLK);
    chk("irq off", IRQ, 1'b0);
    $display("test first interval done");
    wait_req;
    chk("period", cyc - t1, IVL_2K);
    bus(1, `WIT_ADDR_MODE, 32'h80, d);
    @(posedge CORE_CLK);
    chk("write clear", WATCH_IRQ_REQ, 1'b0);
    $display("test second interval done");
    // stopping mid-interval must restart the prescaler from zero
    repeat (3000) @(posedge CORE_CLK);
    bus(1, `WIT_ADDR_MODE, 32'h0, d);
    bus(0, `WIT_ADDR_PERIOD, 0, d); chk("stopped count", d, 32'h0);
    bus(1, `WIT_ADDR_MODE, 32'h80, d);
    wait_req;
    chk("restart interval", n >= IVL_2K - 16 && n <= IVL_2K + 16, 1);
    $display("test restart done");
    // 8192 interval measured from a counter clear in the period register
    bus(1, `WIT_ADDR_MODE, 32'h84, d);
    bus(1, `WIT_ADDR_PERIOD, 32'h85, d);
    chk("clear flag", WATCH_IRQ_REQ, 1'b0);
    wait_req;
    chk("cleared 8k interval", n >= IVL_8K - 16 && n <= IVL_8K + 16, 1);
    bus(0, `WIT_ADDR_MODE, 0, d); chk("8k mode", d, 32'h94);
    $display("test counter clear done");
    test_done;
  end
endmodule
